/* design/ter_top.v */
// Purpose: trigger edge selection and result readout queries behind an APB slave
// Assumes: measurement core on pclk; ext_trigger_input is an asynchronous pin
// Notes:   results formatted as fixed-point text with a range-chosen exponent
`timescale 1ns/10ps
`include "ter_defs.vh"
module ter_top #(
  parameter VAL_W = 25,
  parameter RNG_W = 4
) (
  // apb slave
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // interrupt
  output reg               irq,
  // external control connector
  input  wire              ext_trigger_input,
  // measurement core
  output reg               meas_start,
  input  wire              meas_done,
  input  wire [VAL_W-1:0]  meas_value,
  input  wire [RNG_W-1:0]  meas_range,
  input  wire              meas_over,
  input  wire              meas_fault,
  output reg               range_req,
  input  wire              range_done
);
  localparam TXT_CH = 12;

  // range -> {integer digits, fraction digits, exponent negative, exponent digit}
  function [10:0] range_fmt;
    input [RNG_W-1:0] r;
    begin
      case (r)
        4'd0:    range_fmt = {3'd3, 3'd4, 1'b1, 4'd3};
        4'd1:    range_fmt = {3'd4, 3'd3, 1'b1, 4'd3};
        4'd2:    range_fmt = {3'd2, 3'd5, 1'b0, 4'd0};
        4'd3:    range_fmt = {3'd3, 3'd4, 1'b0, 4'd0};
        4'd4:    range_fmt = {3'd4, 3'd3, 1'b0, 4'd0};
        4'd5:    range_fmt = {3'd2, 3'd4, 1'b0, 4'd3};
        4'd6:    range_fmt = {3'd3, 3'd4, 1'b0, 4'd3};
        4'd7:    range_fmt = {3'd4, 3'd3, 1'b0, 4'd3};
        4'd8:    range_fmt = {3'd2, 3'd5, 1'b0, 4'd6};
        4'd9:    range_fmt = {3'd3, 3'd4, 1'b0, 4'd6};
        default: range_fmt = {3'd3, 3'd4, 1'b0, 4'd6};
      endcase
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `TER_OFS_CTRL) || (a == `TER_OFS_CMD) || (a == `TER_OFS_STATUS) ||
                (a == `TER_OFS_IRQ_STAT) || (a == `TER_OFS_IRQ_MASK) ||
                (a == `TER_OFS_ANS0) || (a == `TER_OFS_ANS1) || (a == `TER_OFS_ANS2);
    end
  endfunction

  reg  [`TER_CTRL_W-1:0]  ctrl;
  reg  [`TER_IRQ_W-1:0]   irq_stat;
  reg  [`TER_IRQ_W-1:0]   irq_mask;
  reg  [`TER_IRQ_W-1:0]   next_irq_stat;
  reg  [2:0]              state;
  reg                     read_pend;
  reg                     latest_valid;
  reg  [8*TXT_CH-1:0]     latest_txt;
  reg  [63:0]             latest_bin;
  reg  [95:0]             ans;
  reg  [VAL_W-1:0]        cap_value;
  reg  [RNG_W-1:0]        cap_range;
  reg                     cap_over;
  reg                     cap_fault;
  reg                     bcd_start;
  reg  [2:0]              ext_trigger_input_sync;
  reg                     ext_trigger_input_pulse;
  reg  [31:0]             rd_mux;
  reg  [8*TXT_CH-1:0]     new_txt;
  reg  [7:0]              ch;
  reg  [10:0]             fmt;
  reg  [3:0]              exp_dig;
  reg  [3:0]              dig;
  reg                     exp_neg;
  reg                     special;
  integer                 p;
  integer                 in_i;
  integer                 tot_i;
  integer                 k;
  wire                    bcd_done;
  wire [31:0]             bcd;
  wire [VAL_W-1:0]        mag;
  wire [63:0]             new_bin;
  wire                    busy;
  wire                    xfer;
  wire                    wr_done;
  wire                    cmd_wr;
  wire                    cmd_fetch;
  wire                    cmd_read;
  wire                    read_err;
  wire                    ext_trigger_input_now;
  wire                    rd_stat;

  // magnitude of a signed result feeds the digit converter
  assign mag     = cap_value[VAL_W-1] ? (~cap_value + {{(VAL_W-1){1'b0}}, 1'b1}) : cap_value;
  assign new_bin = {{(32-RNG_W-2){1'b0}}, cap_fault, cap_over, cap_range,
                    {{(32-VAL_W){cap_value[VAL_W-1]}}, cap_value}};

  // holding pready low stalls the command until the result has been converted
  assign busy      = read_pend && (state != `TER_ST_WAIT) && (state != `TER_ST_IDLE);
  assign xfer      = psel && penable && pready;
  assign wr_done   = xfer && pwrite && !pslverr;
  assign cmd_wr    = wr_done && (paddr == `TER_OFS_CMD);
  assign cmd_fetch = cmd_wr && (pwdata[1:0] == `TER_CMD_FETCH);
  assign cmd_read  = cmd_wr && (pwdata[1:0] == `TER_CMD_READ);
  assign read_err  = cmd_read && (ctrl[`TER_CTRL_CONT_ON] || (state == `TER_ST_WAIT));
  assign rd_stat   = xfer && !pwrite && (paddr == `TER_OFS_IRQ_STAT);
  assign ext_trigger_input_now  = ctrl[`TER_CTRL_EXT_SRC] ? ext_trigger_input_pulse : 1'b1;

  ter_bcd #(
    .BIN_W  (24),
    .DIGITS (8)
  ) u_bcd (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (bcd_start),
    .bin     (mag[23:0]),
    .done    (bcd_done),
    .bcd     (bcd)
  );

  // two flops before use, third only for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_trigger_input_sync  <= 3'h0;
      ext_trigger_input_pulse <= 1'b0;
    end else begin
      ext_trigger_input_sync  <= {ext_trigger_input_sync[1:0], ext_trigger_input};
      ext_trigger_input_pulse <= ctrl[`TER_CTRL_EDGE_FALL] ? (ext_trigger_input_sync[2] & ~ext_trigger_input_sync[1]) :
                                                (~ext_trigger_input_sync[2] & ext_trigger_input_sync[1]);
    end
  end

  // result text assembly
  always @* begin
    fmt     = range_fmt(cap_range);
    in_i    = fmt[10:8];
    // over-range and fault always show seven digits, whatever the range
    tot_i   = (cap_over | cap_fault) ? 7 : fmt[10:8] + fmt[7:5];
    special = cap_over | cap_fault;
    exp_neg = fmt[4] & ~special;
    exp_dig = fmt[3:0];
    if (cap_fault)
      exp_dig = 4'd11 - {1'b0, fmt[10:8]};
    else if (cap_over)
      exp_dig = 4'd10 - {1'b0, fmt[10:8]};
    new_txt = {8*TXT_CH{1'b0}};
    ch      = `TER_CH_SPACE;
    dig     = 4'h0;
    k       = 0;
    for (p = 0; p < TXT_CH; p = p + 1) begin
      k = (p <= in_i) ? p - 1 : p - 2;
      if (special)
        dig = (k == 0) ? 4'h1 : 4'h0;
      else if (k >= 0 && k < tot_i)
        dig = bcd[4*(tot_i-1-k) +: 4];
      else
        dig = 4'h0;
      if (p == 0)
        ch = (cap_value[VAL_W-1] && !cap_fault) ? `TER_CH_MINUS : `TER_CH_SPACE;
      else if (p <= in_i)
        ch = {`TER_CH_DIGIT, dig};
      else if (p == in_i + 1)
        ch = `TER_CH_DOT;
      else if (p <= tot_i + 1)
        ch = {`TER_CH_DIGIT, dig};
      else if (p == tot_i + 2)
        ch = `TER_CH_EXP;
      else if (p == tot_i + 3)
        ch = exp_neg ? `TER_CH_MINUS : `TER_CH_PLUS;
      else if (p == tot_i + 4)
        ch = {`TER_CH_DIGIT, exp_dig};
      else
        ch = `TER_CH_SPACE;
      new_txt[8*p +: 8] = ch;
    end
  end

  // measurement sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= `TER_ST_IDLE;
      read_pend    <= 1'b0;
      meas_start   <= 1'b0;
      range_req    <= 1'b0;
      bcd_start    <= 1'b0;
      cap_value    <= {VAL_W{1'b0}};
      cap_range    <= {RNG_W{1'b0}};
      cap_over     <= 1'b0;
      cap_fault    <= 1'b0;
      latest_txt   <= {8*TXT_CH{1'b0}};
      latest_bin   <= 64'h0;
      latest_valid <= 1'b0;
      ans          <= 96'h0;
    end else begin
      meas_start <= 1'b0;
      range_req  <= 1'b0;
      bcd_start  <= 1'b0;
      if (cmd_fetch)
        ans <= ctrl[`TER_CTRL_BIN_FMT] ? {32'h0, latest_bin} : latest_txt;
      case (state)
        `TER_ST_IDLE: begin
          if (cmd_read && !read_err) begin
            read_pend <= 1'b1;
            state     <= `TER_ST_WAIT;
          end else if (ctrl[`TER_CTRL_CONT_ON])
            state <= `TER_ST_WAIT;
        end
        `TER_ST_WAIT: begin
          if (ext_trigger_input_now) begin
            if (ctrl[`TER_CTRL_AUTO_RNG]) begin
              range_req <= 1'b1;
              state     <= `TER_ST_RANGE;
            end else begin
              meas_start <= 1'b1;
              state      <= `TER_ST_MEAS;
            end
          end else if (!ctrl[`TER_CTRL_CONT_ON] && !read_pend)
            state <= `TER_ST_IDLE;
        end
        `TER_ST_RANGE: begin
          if (range_done) begin
            meas_start <= 1'b1;
            state      <= `TER_ST_MEAS;
          end
        end
        `TER_ST_MEAS: begin
          if (meas_done) begin
            cap_value <= meas_value;
            cap_range <= meas_range;
            cap_over  <= meas_over;
            cap_fault <= meas_fault;
            bcd_start <= 1'b1;
            state     <= `TER_ST_CONV;
          end
        end
        `TER_ST_CONV: begin
          if (bcd_done) begin
            latest_txt   <= new_txt;
            latest_bin   <= new_bin;
            latest_valid <= 1'b1;
            if (read_pend)
              ans <= ctrl[`TER_CTRL_BIN_FMT] ? {32'h0, new_bin} : new_txt;
            read_pend <= 1'b0;
            state     <= ctrl[`TER_CTRL_CONT_ON] ? `TER_ST_WAIT : `TER_ST_IDLE;
          end
        end
        default: state <= `TER_ST_IDLE;
      endcase
    end
  end

  // read mux
  always @* begin
    case (paddr)
      `TER_OFS_CTRL:     rd_mux = {{(32-`TER_CTRL_W){1'b0}}, ctrl};
      `TER_OFS_STATUS:   rd_mux = {27'h0, latest_valid, busy, state};
      `TER_OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat};
      `TER_OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask};
      `TER_OFS_ANS0:     rd_mux = ans[31:0];
      `TER_OFS_ANS1:     rd_mux = ans[63:32];
      `TER_OFS_ANS2:     rd_mux = ans[95:64];
      default:           rd_mux = 32'h0;
    endcase
  end

  // set wins over the read clear; only bits shown to software are cleared
  always @* begin
    next_irq_stat = irq_stat & ~(rd_stat ? prdata[`TER_IRQ_W-1:0] : {`TER_IRQ_W{1'b0}});
    if (read_err)
      next_irq_stat[`TER_IRQ_EXEC_ERR] = 1'b1;
    if (state == `TER_ST_CONV && bcd_done && read_pend)
      next_irq_stat[`TER_IRQ_RESULT] = 1'b1;
    if (cmd_fetch)
      next_irq_stat[`TER_IRQ_RESULT] = 1'b1;
  end

  // apb slave: one access cycle, longer only for a held-off command
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      ctrl     <= `TER_CTRL_RST;
      irq_mask <= `TER_IRQ_MASK_RST;
      irq_stat <= {`TER_IRQ_W{1'b0}};
      irq      <= 1'b0;
    end else begin
      pready <= psel && !(penable && pready) &&
                !(pwrite && (paddr == `TER_OFS_CMD) && busy);
      if (psel && !pready) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= !addr_ok(paddr);
      end else if (xfer) begin
        pslverr <= 1'b0;
      end
      if (wr_done && paddr == `TER_OFS_CTRL)
        ctrl <= pwdata[`TER_CTRL_W-1:0];
      if (wr_done && paddr == `TER_OFS_IRQ_MASK)
        irq_mask <= pwdata[`TER_IRQ_W-1:0];
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_mask);
    end
  end
endmodule

/* design/ter_defs.vh */
// Purpose: register map, field positions, reset values and codes of the trigger/readout block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   included by ter_top.v and by the property checker and bench (not by the core model)
`ifndef TER_DEFS_VH
`define TER_DEFS_VH

// register byte offsets
`define TER_OFS_CTRL      8'h00
`define TER_OFS_CMD       8'h04
`define TER_OFS_STATUS    8'h08
`define TER_OFS_IRQ_STAT  8'h0c
`define TER_OFS_IRQ_MASK  8'h10
`define TER_OFS_ANS0      8'h14
`define TER_OFS_ANS1      8'h18
`define TER_OFS_ANS2      8'h1c

// control register fields
`define TER_CTRL_EDGE_FALL  0
`define TER_CTRL_EXT_SRC    1
`define TER_CTRL_CONT_ON    2
`define TER_CTRL_BIN_FMT    3
`define TER_CTRL_AUTO_RNG   4
`define TER_CTRL_W          5
`define TER_CTRL_RST        5'h00

// command codes, written into the low bits of the command register
`define TER_CMD_FETCH     2'h1
`define TER_CMD_READ      2'h2

// interrupt status and mask fields
`define TER_IRQ_EXEC_ERR  0
`define TER_IRQ_RESULT    1
`define TER_IRQ_W         2
`define TER_IRQ_MASK_RST  2'h0

// fsm state codes
`define TER_ST_IDLE       3'h0
`define TER_ST_WAIT       3'h1
`define TER_ST_RANGE      3'h2
`define TER_ST_MEAS       3'h3
`define TER_ST_CONV       3'h4

// text characters
`define TER_CH_SPACE      8'h20
`define TER_CH_MINUS      8'h2d
`define TER_CH_PLUS       8'h2b
`define TER_CH_DOT        8'h2e
`define TER_CH_EXP        8'h45
`define TER_CH_DIGIT      4'h3

`endif

/* design/ter_bcd.v */
// Purpose: sequential binary to packed-bcd converter (shift and add three)
// Assumes: start is a one-cycle pulse, ignored while a conversion runs
// Notes:   takes BIN_W cycles; done pulses one cycle with bcd valid
`timescale 1ns/10ps
module ter_bcd #(
  parameter BIN_W  = 24,
  parameter DIGITS = 8
) (
  // clock and reset
  input  wire                  pclk,
  input  wire                  presetn,
  // request
  input  wire                  start,
  input  wire [BIN_W-1:0]      bin,
  // answer
  output reg                   done,
  output reg  [4*DIGITS-1:0]   bcd
);
  localparam CW = $clog2(BIN_W + 1);

  reg  [BIN_W-1:0]    sh_bin;
  reg  [CW-1:0]       cnt;
  reg                 run;
  reg  [4*DIGITS-1:0] adj;
  integer             d;

  // add three to every digit of five or more before each shift
  always @* begin
    adj = bcd;
    for (d = 0; d < DIGITS; d = d + 1) begin
      if (bcd[4*d +: 4] >= 4'h5)
        adj[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_bin <= {BIN_W{1'b0}};
      bcd    <= {4*DIGITS{1'b0}};
      cnt    <= {CW{1'b0}};
      run    <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !run) begin
        sh_bin <= bin;
        bcd    <= {4*DIGITS{1'b0}};
        cnt    <= BIN_W[CW-1:0];
        run    <= 1'b1;
      end else if (run) begin
        {bcd, sh_bin} <= {adj[4*DIGITS-2:0], sh_bin, 1'b0};
        cnt           <= cnt - {{(CW-1){1'b0}}, 1'b1};
        if (cnt == {{(CW-1){1'b0}}, 1'b1}) begin
          run  <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

/* verif/ter_core_model.sv */
// Purpose: behavioural measurement core facing the readout block
// Assumes: one measurement at a time, started by a one-cycle meas_start
// Notes:   result lines are scrambled outside the meas_done cycle on purpose
`timescale 1ns/10ps
module ter_core_model #(
  parameter DELAY = 30
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // requests from the block
  input  wire         meas_start,
  input  wire         range_req,
  // result the bench wants returned
  input  wire [24:0]  cfg_value,
  input  wire [3:0]   cfg_range,
  input  wire         cfg_over,
  input  wire         cfg_fault,
  // answers to the block
  output logic        meas_done,
  output logic [24:0] meas_value,
  output logic [3:0]  meas_range,
  output logic        meas_over,
  output logic        meas_fault,
  output logic        range_done,
  // activity counters
  output int          n_start,
  output int          n_range
);
  int cnt;
  int rcnt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {meas_done, range_done, meas_over, meas_fault} <= 4'h0;
      meas_value <= 25'h0;
      meas_range <= 4'h0;
      {cnt, rcnt, n_start, n_range} <= '0;
    end else begin
      // no stale value may pass for a result
      meas_done  <= 1'b0;
      range_done <= 1'b0;
      meas_value <= ~cfg_value;
      meas_range <= ~cfg_range;
      meas_over  <= ~cfg_over;
      meas_fault <= ~cfg_fault;
      if (meas_start) begin
        cnt     <= DELAY;
        n_start <= n_start + 1;
      end else if (cnt == 1) begin
        cnt        <= 0;
        meas_done  <= 1'b1;
        meas_value <= cfg_value;
        meas_range <= cfg_range;
        meas_over  <= cfg_over;
        meas_fault <= cfg_fault;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
      if (range_req) begin
        rcnt    <= 3;
        n_range <= n_range + 1;
      end else if (rcnt == 1) begin
        rcnt       <= 0;
        range_done <= 1'b1;
      end else if (rcnt > 1) begin
        rcnt <= rcnt - 1;
      end
    end
  end
endmodule

/* verif/ter_top_properties.sv */
// Purpose: port-level checks of the trigger/readout block
// Assumes: apb slave with zero wait states except stalled command writes
// Notes:   bound into every ter_top instance
`timescale 1ns/10ps
`include "ter_defs.vh"
module ter_top_checker (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // interrupt and core link
  input wire        irq,
  input wire        meas_start,
  input wire        range_req,
  input wire        range_done
);
  wire unmapped = (paddr > 8'h1c) || (paddr[1:0] != 2'h0);
  wire rd_now   = pready && !pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pready_one_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_prompt_a: assert property (psel && !penable && paddr != `TER_OFS_CMD |=> pready)
    else $error("access not answered at once");
  unmapped_err_a: assert property (pready && unmapped |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (pready && !unmapped |-> !pslverr)
    else $error("mapped access flagged as error");
  unmapped_zero_a: assert property (rd_now && unmapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  cmd_reads_zero_a: assert property (rd_now && paddr == `TER_OFS_CMD |-> prdata == 32'h0)
    else $error("command register read not zero");
  ctrl_fields_a: assert property (rd_now && paddr == `TER_OFS_CTRL |-> prdata[31:5] == 27'h0)
    else $error("control readback has stray bits");
  status_state_a: assert property (rd_now && paddr == `TER_OFS_STATUS |->
    prdata[2:0] <= 3'h4 && prdata[31:5] == 27'h0)
    else $error("status shows bad state");
  meas_single_a: assert property (meas_start |=> !meas_start [*8])
    else $error("measurement restarted too soon");
  range_pulse_a: assert property (range_req |=> !range_req)
    else $error("range request longer than one cycle");
  range_first_a: assert property (range_done |=> meas_start)
    else $error("no start after range chosen");

  cover property (meas_start);
  cover property (range_done ##1 meas_start);
  cover property (pready && pslverr);
  cover property (!irq ##1 irq);
endmodule
bind ter_top ter_top_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .irq, .meas_start, .range_req, .range_done);

/* verif/ter_top_tb.sv */
// Purpose: register-level bench of the trigger/readout block
// Assumes: core model answers DELAY cycles after each start
// Notes:   a stalled command write doubles as the wait for a result
`timescale 1ns/10ps
`include "ter_defs.vh"
module ter_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, ext_trigger_input, err;
  logic        cfg_over, cfg_fault;
  logic [3:0]  cfg_range;
  logic [24:0] cfg_value;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  wire  [31:0] prdata;
  wire  [24:0] meas_value;
  wire  [3:0]  meas_range;
  wire         pready, pslverr, irq, meas_start, meas_done, meas_over, meas_fault;
  wire         range_req, range_done;
  int          n_start, n_range, fails, tests_run, snap;

  ter_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .ext_trigger_input, .meas_start, .meas_done, .meas_value,
    .meas_range, .meas_over, .meas_fault, .range_req, .range_done);
  ter_core_model core (.pclk, .presetn, .meas_start, .range_req, .cfg_value, .cfg_range,
    .cfg_over, .cfg_fault, .meas_done, .meas_value, .meas_range, .meas_over, .meas_fault,
    .range_done, .n_start, .n_range);

  always #5 pclk = ~pclk;

  task wrap_up();
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // called just after a rising edge; ends one edge after release
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit tmo;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    q   = prdata;
    err = pslverr;
    tmo = (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (tmo) begin
      fails++;
      wrap_up();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task set(input logic [24:0] v, input logic [3:0] r, input logic o, input logic f);
    cfg_value <= v;
    cfg_range <= r;
    cfg_over  <= o;
    cfg_fault <= f;
  endtask

  task ans_chk(input logic [95:0] s);
    logic [31:0] w [3];
    for (int p = 0; p < 12; p++)
      w[p/4][8*(p%4) +: 8] = s[95-8*p -: 8];
    for (int i = 0; i < 3; i++) begin
      rd(`TER_OFS_ANS0 + 8'(4*i));
      check(q, w[i]);
    end
  endtask

  task meas_read();
    wr(`TER_OFS_CMD, {30'h0, `TER_CMD_READ});
    wr(`TER_OFS_CMD, {30'h0, `TER_CMD_FETCH});
    rd(`TER_OFS_STATUS);
    check(q & 32'h7, 32'h0);
  endtask

  task wait_idle();
    int n;
    n = 0;
    do begin
      rd(`TER_OFS_STATUS);
      n++;
    end while (q[2:0] !== 3'h0 && n < 100);
    if (q[2:0] !== 3'h0) begin
      fails++;
      wrap_up();
    end
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, ext_trigger_input} = 6'h0;
    paddr  = 8'h0;
    pwdata = 32'h0;
    {fails, tests_run} = '0;
    set(25'h0, 4'h0, 1'b0, 1'b0);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`TER_OFS_CTRL);
    check(q, 32'h0);
    rd(`TER_OFS_IRQ_MASK);
    check(q, 32'h0);
    rd(`TER_OFS_STATUS);
    check(q, 32'h0);
    rd(8'h20);
    check({31'h0, err}, 32'h1);
    rd(`TER_OFS_CMD);
    check(q, 32'h0);
    wr(`TER_OFS_IRQ_MASK, 32'h3);
    set(25'd1234567, 4'h0, 1'b0, 1'b0);
    meas_read();
    ans_chk(" 123.4567E-3");
    @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    rd(`TER_OFS_IRQ_STAT);
    check(q, 32'h2);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    // masked event stays sticky but quiet
    wr(`TER_OFS_IRQ_MASK, 32'h0);
    set(-25'd1234567, 4'h0, 1'b0, 1'b0);
    meas_read();
    ans_chk("-123.4567E-3");
    check({31'h0, irq}, 32'h0);
    rd(`TER_OFS_IRQ_STAT);
    check(q, 32'h2);
    set(25'd7, 4'h0, 1'b0, 1'b0);
    snap = n_start;
    wr(`TER_OFS_CMD, {30'h0, `TER_CMD_FETCH});
    ans_chk("-123.4567E-3");
    check(n_start, snap);
    set(25'd123456, 4'h5, 1'b0, 1'b0);
    meas_read();
    ans_chk(" 12.3456E+3 ");
    set(25'd5, 4'h8, 1'b1, 1'b0);
    meas_read();
    ans_chk(" 10.00000E+8");
    set(25'd5, 4'h8, 1'b0, 1'b1);
    meas_read();
    ans_chk(" 10.00000E+9");
    set(-25'd5, 4'h5, 1'b1, 1'b0);
    meas_read();
    ans_chk("-10.00000E+8");
    set(25'd5, 4'h5, 1'b0, 1'b1);
    meas_read();
    ans_chk(" 10.00000E+9");
    wr(`TER_OFS_CTRL, 32'h8);
    set(-25'd5, 4'h3, 1'b1, 1'b0);
    meas_read();
    rd(`TER_OFS_ANS0);
    check(q, 32'hfffffffb);
    rd(`TER_OFS_ANS1);
    check(q, 32'h13);
    rd(`TER_OFS_ANS2);
    check(q, 32'h0);
    wr(`TER_OFS_CTRL, 32'h10);
    snap = n_range;
    set(25'd1234567, 4'h0, 1'b0, 1'b0);
    meas_read();
    check(n_range, snap + 1);
    ans_chk(" 123.4567E-3");
    // falling edge active; host keeps auto sending off
    wr(`TER_OFS_CTRL, 32'h3);
    rd(`TER_OFS_CTRL);
    check(q, 32'h3);
    wr(`TER_OFS_CMD, {30'h0, `TER_CMD_READ});
    rd(`TER_OFS_STATUS);
    check(q & 32'h7, 32'h1);
    wr(`TER_OFS_CMD, {30'h0, `TER_CMD_READ});
    rd(`TER_OFS_IRQ_STAT);
    check(q & 32'h1, 32'h1);
    snap = n_start;
    ext_trigger_input <= 1'b1;
    repeat (12) @(posedge pclk);
    check(n_start, snap);
    ext_trigger_input <= 1'b0;
    wait_idle();
    check(n_start, snap + 1);
    ans_chk(" 123.4567E-3");
    wr(`TER_OFS_CTRL, 32'h2);
    wr(`TER_OFS_CMD, {30'h0, `TER_CMD_READ});
    snap = n_start;
    ext_trigger_input <= 1'b1;
    wait_idle();
    check(n_start, snap + 1);
    wr(`TER_OFS_CTRL, 32'h4);
    wr(`TER_OFS_CMD, {30'h0, `TER_CMD_READ});
    rd(`TER_OFS_IRQ_STAT);
    check(q & 32'h1, 32'h1);
    snap = n_start;
    repeat (200) @(posedge pclk);
    check({31'h0, n_start > snap + 1}, 32'h1);
    wr(`TER_OFS_CTRL, 32'h0);
    wait_idle();
    snap = n_start;
    repeat (100) @(posedge pclk);
    check(n_start, snap);
    wrap_up();
  end
endmodule
